// ### cfsg_top.sv
`timescale 1ns/100ps
module cfsg_top #(
	parameter int unsigned NUM_MOD = 8,
	parameter logic [NUM_MOD-1:0] MOD_PRESENT = '1,
	parameter int unsigned PLL_W = 5
) (
	input wire logic pclk, // System clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [cfsg_pkg::ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	input wire logic clock_switch_monitor_cfg, // Configuration bit, one disables monitor.
	input wire logic osc_fail, // Monitored oscillator failed, asynchronous level.
	input wire logic [PLL_W-1:0] pll_mult_in, // PLL factor chosen by the oscillator logic.
	input wire logic wdt_enable, // Watchdog enabled.
	input wire logic wdt_timeout, // Watchdog time-out pulse.
	input wire logic irq_pend, // Any individually enabled interrupt pending.
	input wire logic power_save_instr, // Power-save instruction executes, pulse.
	input wire logic power_save_sleep, // Mode of that instruction: one Sleep, zero Idle.
	input wire logic trap_ack, // CPU acknowledges the clock-failure trap.
	output logic sys_src, // System clock source select.
	output logic [PLL_W-1:0] pll_mult_out, // PLL factor applied to the selected source.
	output logic sys_clk_en, // System clock running.
	output logic low_power_rc_osc_en, // Low-power RC oscillator enable.
	output logic watchdog_timer_clr, // Watchdog clear pulse.
	output logic trap_req, // Clock-failure trap request level.
	output logic cpu_run, // CPU allowed to execute.
	output logic cpu_clk_en, // CPU clock enable pulse.
	output logic cpu_resume, // Wake pulse to the CPU.
	output logic [NUM_MOD-1:0] periph_clk_en, // Per-module clock enable.
	output logic [NUM_MOD-1:0] periph_reg_en, // Per-module register access enable.
	output logic irq // Level interrupt.
);

	// Two-flop synchronisers for pin inputs.
	logic cfg_meta_q;
	logic cfg_sync_q;
	logic fail_meta_q;
	logic fail_sync_q;

	// Register state.
	cfsg_pkg::cfsg_clock_div_t clock_div_q;
	logic [NUM_MOD-1:0] gate_q;
	logic [cfsg_pkg::IRQ_W-1:0] irq_stat_q;
	logic [cfsg_pkg::IRQ_W-1:0] irq_stat_d;
	logic [cfsg_pkg::IRQ_W-1:0] irq_en_q;
	logic [cfsg_pkg::IRQ_W-1:0] irq_ev;

	// Clock and power state.
	cfsg_pkg::cfsg_pwr_t pwr_q;
	logic src_q;
	logic [PLL_W-1:0] pll_q;
	logic trap_q;
	logic [cfsg_pkg::DOZE_CNT_W-1:0] doze_cnt_q;
	logic [cfsg_pkg::DOZE_CNT_W-1:0] doze_lim;
	logic doze_tick;

	// Bus decode.
	logic setup;
	logic wr_en;
	logic [31:0] rd_d;
	logic err_d;
	logic monitor_en;
	logic fail_ev;
	logic wake_ev;
	logic ret_ev;
	logic restore;
	cfsg_pkg::cfsg_status_t status;

	// The configuration level is synchronised; reset loads the disabled value.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_meta_q <= 1'b1;
			cfg_sync_q <= 1'b1;
		end else begin
			cfg_meta_q <= clock_switch_monitor_cfg;
			cfg_sync_q <= cfg_meta_q;
		end
	end

	// The failure flag crosses from the oscillator domain.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fail_meta_q <= 1'b0;
			fail_sync_q <= 1'b0;
		end else begin
			fail_meta_q <= osc_fail;
			fail_sync_q <= fail_meta_q;
		end
	end

	// A programmed zero enables both clock switching and the monitor.
	assign monitor_en = ~cfg_sync_q;

	// Failover only fires once, while still on the primary source.
	assign fail_ev = fail_sync_q & monitor_en & (src_q == cfsg_pkg::SRC_PRIMARY);

	// Software may only return to the primary source once it has recovered.
	assign restore = wr_en & (paddr == cfsg_pkg::OFF_CTRL) & pwdata[cfsg_pkg::CTRL_RESTORE_BIT]
		& monitor_en & ~fail_sync_q & (src_q == cfsg_pkg::SRC_FAST_RC);

	// APB phases: the slave answers in the first access cycle.
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite & pready;

	// Read data mux and unmapped decode, sampled in the setup cycle.
	always_comb begin
		rd_d = 32'h0000_0000;
		err_d = 1'b0;
		if (paddr == cfsg_pkg::OFF_CLOCK_DIV) begin
			rd_d[cfsg_pkg::DIV_RETURN_BIT] = clock_div_q.ret_on_irq;
			rd_d[cfsg_pkg::DIV_RATIO_LO +: cfsg_pkg::RATIO_W] = clock_div_q.ratio;
			rd_d[cfsg_pkg::DIV_SLOW_BIT] = clock_div_q.slow_en;
		end else if (paddr == cfsg_pkg::OFF_CTRL) begin
			rd_d = 32'h0000_0000;
		end else if (paddr == cfsg_pkg::OFF_GATE) begin
			rd_d[NUM_MOD-1:0] = gate_q;
		end else if (paddr == cfsg_pkg::OFF_STATUS) begin
			rd_d[$bits(cfsg_pkg::cfsg_status_t)-1:0] = status;
		end else if (paddr == cfsg_pkg::OFF_IRQ_STAT) begin
			rd_d[cfsg_pkg::IRQ_W-1:0] = irq_stat_q;
		end else if (paddr == cfsg_pkg::OFF_IRQ_CLR) begin
			rd_d = 32'h0000_0000;
		end else if (paddr == cfsg_pkg::OFF_IRQ_EN) begin
			rd_d[cfsg_pkg::IRQ_W-1:0] = irq_en_q;
		end else begin
			err_d = 1'b1;
		end
	end

	// Status view of the block's own state.
	always_comb begin
		status.ratio = clock_div_q.ratio;
		status.doze_active = clock_div_q.slow_en;
		status.sleeping = (pwr_q == cfsg_pkg::CFSG_SLEEP);
		status.idling = (pwr_q == cfsg_pkg::CFSG_IDLE);
		status.trap_pend = trap_q;
		status.monitor_en = monitor_en;
		status.src = src_q;
	end

	// Bus answer flops: ready rises for exactly one access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_d;
				pslverr <= err_d;
			end else begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

	// Clock divider register; an interrupt with return-on-interrupt drops slowdown.
	// A software write in the same cycle wins, so a fresh setting is never lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_div_q <= cfsg_pkg::DIV_RST;
		end else if (wr_en && paddr == cfsg_pkg::OFF_CLOCK_DIV) begin
			clock_div_q.ret_on_irq <= pwdata[cfsg_pkg::DIV_RETURN_BIT];
			clock_div_q.ratio <= pwdata[cfsg_pkg::DIV_RATIO_LO +: cfsg_pkg::RATIO_W];
			clock_div_q.slow_en <= pwdata[cfsg_pkg::DIV_SLOW_BIT];
		end else if (ret_ev) begin
			clock_div_q.slow_en <= 1'b0;
		end
	end

	// Interrupts leave Doze alone unless return-on-interrupt is set.
	assign ret_ev = clock_div_q.ret_on_irq & clock_div_q.slow_en & irq_pend;

	// Divisor is two to the power of the ratio code.
	assign doze_lim = ~(cfsg_pkg::DOZE_ALL_ONES << clock_div_q.ratio);
	assign doze_tick = ~clock_div_q.slow_en | (doze_cnt_q >= doze_lim);

	// Doze counter runs on the system clock, so both domains share one edge grid.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			doze_cnt_q <= '0;
		end else if (doze_tick) begin
			doze_cnt_q <= '0;
		end else begin
			doze_cnt_q <= doze_cnt_q + 1'b1;
		end
	end

	// CPU clock enable only runs while executing; peripherals never see the divider.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clk_en <= 1'b0;
		end else begin
			cpu_clk_en <= doze_tick & (pwr_q == cfsg_pkg::CFSG_RUN);
		end
	end

	// Module gate register; absent modules always read as gated.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_q <= ~MOD_PRESENT;
		end else if (wr_en && paddr == cfsg_pkg::OFF_GATE) begin
			gate_q <= pwdata[NUM_MOD-1:0] | ~MOD_PRESENT;
		end
	end

	// Each gate reaches its module one cycle after the register changes.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MOD; gi++) begin : g_mod
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					periph_clk_en[gi] <= 1'b0;
					periph_reg_en[gi] <= 1'b0;
				end else begin
					periph_clk_en[gi] <= ~gate_q[gi] & MOD_PRESENT[gi];
					periph_reg_en[gi] <= ~gate_q[gi] & MOD_PRESENT[gi];
				end
			end
		end
	endgenerate

	// Clock source and PLL factor. The factor is tracked until failure,
	// then frozen so the fast RC runs at the multiplied rate.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q <= cfsg_pkg::SRC_PRIMARY;
			pll_q <= '0;
		end else if (fail_ev) begin
			src_q <= cfsg_pkg::SRC_FAST_RC;
		end else if (restore) begin
			src_q <= cfsg_pkg::SRC_PRIMARY;
		end else if (src_q == cfsg_pkg::SRC_PRIMARY) begin
			pll_q <= pll_mult_in;
		end
	end

	// Trap request holds until acknowledged; a new failure beats the acknowledge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_q <= 1'b0;
		end else if (fail_ev) begin
			trap_q <= 1'b1;
		end else if (trap_ack) begin
			trap_q <= 1'b0;
		end
	end

	// Wake sources for Idle and Sleep; reset wakes by returning the state to run.
	assign wake_ev = (pwr_q == cfsg_pkg::CFSG_IDLE) & (irq_pend | wdt_timeout)
		| (pwr_q == cfsg_pkg::CFSG_SLEEP) & irq_pend;

	// Power-save sequencer. The enter state ignores wake sources, so a
	// coincident interrupt is served only after entry completes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_q <= cfsg_pkg::CFSG_RUN;
		end else begin
			case (pwr_q)
				cfsg_pkg::CFSG_RUN: begin
					if (power_save_instr) begin
						pwr_q <= cfsg_pkg::CFSG_ENTER;
					end
				end
				cfsg_pkg::CFSG_ENTER: begin
					pwr_q <= power_save_sleep ? cfsg_pkg::CFSG_SLEEP : cfsg_pkg::CFSG_IDLE;
				end
				default: begin
					if (wake_ev) begin
						pwr_q <= cfsg_pkg::CFSG_RUN;
					end
				end
			endcase
		end
	end

	// Mode sampled in the enter state, the cycle after the instruction; held stable by the CPU while it runs.
	// Sequencer outputs: execution stops from entry, resumes the cycle after wake.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_run <= 1'b1;
			cpu_resume <= 1'b0;
			watchdog_timer_clr <= 1'b0;
			sys_clk_en <= 1'b1;
		end else begin
			cpu_run <= (pwr_q == cfsg_pkg::CFSG_RUN) & ~power_save_instr | wake_ev;
			cpu_resume <= wake_ev;
			watchdog_timer_clr <= (pwr_q == cfsg_pkg::CFSG_ENTER) & ~power_save_sleep;
			sys_clk_en <= (pwr_q != cfsg_pkg::CFSG_SLEEP) | wake_ev;
		end
	end

	// Low-power RC: the monitor forces it on regardless of the watchdog, except in Sleep.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_power_rc_osc_en <= 1'b0;
		end else begin
			low_power_rc_osc_en <= (monitor_en | wdt_enable) & (pwr_q != cfsg_pkg::CFSG_SLEEP);
		end
	end

	// Source and trap outputs come straight from their flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_src <= cfsg_pkg::SRC_PRIMARY;
			pll_mult_out <= '0;
			trap_req <= 1'b0;
		end else begin
			sys_src <= src_q;
			pll_mult_out <= (src_q == cfsg_pkg::SRC_PRIMARY) ? pll_mult_in : pll_q;
			trap_req <= trap_q;
		end
	end

	// Interrupt events: failover, wake from a power-save mode, doze return.
	always_comb begin
		irq_ev = '0;
		irq_ev[cfsg_pkg::IRQ_FAIL] = fail_ev;
		irq_ev[cfsg_pkg::IRQ_WAKE] = wake_ev;
		irq_ev[cfsg_pkg::IRQ_RETURN] = ret_ev;
		irq_stat_d = irq_stat_q;
		if (wr_en && paddr == cfsg_pkg::OFF_IRQ_CLR) begin
			irq_stat_d = irq_stat_q & ~pwdata[cfsg_pkg::IRQ_W-1:0];
		end
		// A set in the clearing cycle still lands.
		irq_stat_d = irq_stat_d | irq_ev;
	end

	// Sticky status, enable mask and interrupt line.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= cfsg_pkg::IRQ_RST;
			irq_en_q <= cfsg_pkg::IRQ_RST;
			irq <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			if (wr_en && paddr == cfsg_pkg::OFF_IRQ_EN) begin
				irq_en_q <= pwdata[cfsg_pkg::IRQ_W-1:0];
			end
			irq <= |(irq_stat_d & irq_en_q);
		end
	end

endmodule

// ### cfsg_pkg.sv
package cfsg_pkg;

	// Register byte offsets on the APB port.
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFF_CLOCK_DIV = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_GATE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
	localparam logic [7:0] OFF_IRQ_EN = 8'h18;

	// Field positions in the clock divider register.
	localparam int unsigned DIV_RETURN_BIT = 15;
	localparam int unsigned DIV_RATIO_LO = 12;
	localparam int unsigned DIV_SLOW_BIT = 11;
	localparam int unsigned RATIO_W = 3;

	// Control register: write one to hand the system clock back to the primary oscillator.
	localparam int unsigned CTRL_RESTORE_BIT = 0;

	// Interrupt status bit positions.
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned IRQ_FAIL = 0;
	localparam int unsigned IRQ_WAKE = 1;
	localparam int unsigned IRQ_RETURN = 2;
	localparam logic [2:0] IRQ_RST = 3'h0;

	// Doze counter width covers the 1:128 ratio.
	localparam int unsigned DOZE_CNT_W = 7;
	localparam logic [6:0] DOZE_ALL_ONES = 7'h7F;

	// System clock source codes.
	localparam logic SRC_PRIMARY = 1'b0;
	localparam logic SRC_FAST_RC = 1'b1;

	// Reset value of the module gates: every present module enabled.
	localparam logic GATE_RST = 1'b0;

	// Clock divider fields, reset to 1:1 with slowdown off.
	typedef struct packed {
		logic ret_on_irq;
		logic [2:0] ratio;
		logic slow_en;
	} cfsg_clock_div_t;

	localparam cfsg_clock_div_t DIV_RST = '{ret_on_irq: 1'b0, ratio: 3'h0, slow_en: 1'b0};

	// Status word fields, packed into the low bits of the status register.
	typedef struct packed {
		logic [2:0] ratio;
		logic doze_active;
		logic sleeping;
		logic idling;
		logic trap_pend;
		logic monitor_en;
		logic src;
	} cfsg_status_t;

	// Power-save sequencing states.
	typedef enum logic [1:0] {
		CFSG_RUN,
		CFSG_ENTER,
		CFSG_IDLE,
		CFSG_SLEEP
	} cfsg_pwr_t;

endpackage

// ### cfsg_properties.sv
`timescale 1ns/100ps
// Port checker; idle_q marks Idle from the watchdog clear pulse until the first wake cause.
module cfsg_properties #(
	parameter int unsigned NUM_MOD = 8,
	parameter logic [NUM_MOD-1:0] MOD_PRESENT = '1,
	parameter int unsigned PLL_W = 5
) (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Reset.
	input wire logic psel, // Select.
	input wire logic penable, // Enable.
	input wire logic pwrite, // Direction.
	input wire logic [cfsg_pkg::ADDR_W-1:0] paddr, // Address.
	input wire logic [31:0] pwdata, // Write data.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	input wire logic clock_switch_monitor_cfg, // Config bit.
	input wire logic osc_fail, // Failure.
	input wire logic wdt_enable, // Watchdog on.
	input wire logic wdt_timeout, // Time-out.
	input wire logic irq_pend, // Interrupt.
	input wire logic power_save_instr, // Power save.
	input wire logic power_save_sleep, // Sleep mode.
	input wire logic trap_ack, // Acknowledge.
	input wire logic sys_src, // Source.
	input wire logic [PLL_W-1:0] pll_mult_out, // Factor.
	input wire logic sys_clk_en, // System clock.
	input wire logic low_power_rc_osc_en, // Slow RC.
	input wire logic watchdog_timer_clr, // Clear.
	input wire logic trap_req, // Trap.
	input wire logic cpu_run, // Run.
	input wire logic cpu_resume, // Wake.
	input wire logic [NUM_MOD-1:0] periph_clk_en, // Clocks.
	input wire logic [NUM_MOD-1:0] periph_reg_en // Registers.
);
	logic idle_q;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Built from inputs only, so a design that never wakes cannot hide the check.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_q <= 1'b0;
		end else begin
			idle_q <= (watchdog_timer_clr || idle_q) && !(irq_pend || wdt_timeout);
		end
	end

	a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready) else $error("bad pready");
	a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_fail_over: assert property ($rose(osc_fail) && !clock_switch_monitor_cfg && !sys_src |->
		##[2:8] (sys_src && trap_req)) else $error("no failover");
	a_trap_hold: assert property (trap_req && !trap_ack && !$past(trap_ack) && !$past(trap_ack, 2)
		|=> trap_req) else $error("trap dropped early");
	a_pll_freeze: assert property (sys_src && $past(sys_src) |-> $stable(pll_mult_out)) else $error("factor moved");
	a_idle_entry: assert property (power_save_instr && !power_save_sleep |=> !cpu_run ##1 watchdog_timer_clr)
		else $error("idle entry wrong");
	a_hold_off: assert property (power_save_instr |=> (!cpu_resume && !cpu_run) [*2]) else $error("early wake");
	a_idle_wake: assert property ((watchdog_timer_clr || idle_q) && (irq_pend || wdt_timeout)
		|=> cpu_resume && cpu_run) else $error("no wake");
	a_idle_clock: assert property (watchdog_timer_clr || idle_q |-> sys_clk_en) else $error("clock off in idle");
	a_slow_rc_wdt: assert property (wdt_enable && $past(wdt_enable) && $past(presetn) && sys_clk_en
		&& $past(sys_clk_en) |-> low_power_rc_osc_en) else $error("slow RC off");
	a_gate_apply: assert property (psel && penable && pready && pwrite && paddr == cfsg_pkg::OFF_GATE
		|=> ##1 periph_clk_en == (~$past(pwdata[NUM_MOD-1:0], 2) & MOD_PRESENT)) else $error("gate wrong");
	a_reg_gate: assert property (periph_reg_en == periph_clk_en) else $error("register gate wrong");
	c_trap: cover property (trap_req && trap_ack);
	c_wake: cover property (cpu_resume);
	c_err: cover property (pslverr);
endmodule

bind cfsg_top cfsg_properties #(.NUM_MOD(NUM_MOD), .MOD_PRESENT(MOD_PRESENT), .PLL_W(PLL_W)) i_cfsg_properties (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .clock_switch_monitor_cfg,
	.osc_fail, .wdt_enable, .wdt_timeout, .irq_pend, .power_save_instr, .power_save_sleep, .trap_ack, .sys_src,
	.pll_mult_out, .sys_clk_en, .low_power_rc_osc_en, .watchdog_timer_clr, .trap_req, .cpu_run, .cpu_resume,
	.periph_clk_en, .periph_reg_en);

// ### cfsg_cpu_model.sv
`timescale 1ns/100ps
// CPU side: a slow trap handler and a counter of CPU clock ticks.
module cfsg_cpu_model (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Reset, active low.
	input wire logic trap_req, // Trap request.
	input wire logic cpu_clk_en, // CPU tick.
	input wire logic [7:0] ack_delay, // Handler latency.
	output logic trap_ack, // Acknowledge pulse.
	output logic [15:0] ticks, // Ticks seen.
	output logic [7:0] acks // Acknowledges given.
);
	logic [7:0] wait_q;

	// The handler answers late, so a request that does not stand is missed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_ack <= 1'b0;
			wait_q <= 8'h00;
			acks <= 8'h00;
		end else begin
			trap_ack <= 1'b0;
			if (trap_req && !trap_ack) begin
				wait_q <= (wait_q == ack_delay) ? 8'h00 : wait_q + 8'h01;
				if (wait_q == ack_delay) begin
					trap_ack <= 1'b1;
					acks <= acks + 8'h01;
				end
			end
		end
	end

	// Tick count lets the bench measure the slowdown ratio.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ticks <= 16'h0000;
		end else begin
			ticks <= ticks + {15'h0000, cpu_clk_en};
		end
	end
endmodule

// ### cfsg_top_tb.sv
`timescale 1ns/100ps
module cfsg_top_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [cfsg_pkg::ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic clock_switch_monitor_cfg, osc_fail, wdt_enable, wdt_timeout, irq_pend, trap_ack, trap_req;
	logic power_save_instr, power_save_sleep, sys_src, sys_clk_en, low_power_rc_osc_en, irq;
	logic watchdog_timer_clr, cpu_run, cpu_clk_en, cpu_resume;
	logic [4:0] pll_mult_in, pll_mult_out;
	logic [7:0] periph_clk_en, periph_reg_en, acks;
	logic [15:0] ticks, t0;
	int fails, check_count, n;

	cfsg_top #(.MOD_PRESENT(8'h7F)) i_cfsg_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .clock_switch_monitor_cfg, .osc_fail, .pll_mult_in, .wdt_enable, .wdt_timeout,
		.irq_pend, .power_save_instr, .power_save_sleep, .trap_ack, .sys_src, .pll_mult_out, .sys_clk_en,
		.low_power_rc_osc_en, .watchdog_timer_clr, .trap_req, .cpu_run, .cpu_clk_en, .cpu_resume, .periph_clk_en,
		.periph_reg_en, .irq);
	cfsg_cpu_model i_cfsg_cpu_model (.pclk, .presetn, .trap_req, .cpu_clk_en, .ack_delay(8'h08), .trap_ack,
		.ticks, .acks);

	// Free-running system clock.
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; waits for pready and never assumes a latency.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No timeout of its own; if pready never comes, only the bench watchdog ends this wait.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask

	task automatic psave(input logic sl, input logic with_irq);
		@(posedge pclk);
		power_save_sleep <= sl;
		power_save_instr <= 1'b1;
		irq_pend <= with_irq;
		@(posedge pclk);
		power_save_instr <= 1'b0;
	endtask

	task automatic results;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic t_regs;
		apb(1'b0, cfsg_pkg::OFF_CLOCK_DIV, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "divider reset");
		apb(1'b0, cfsg_pkg::OFF_GATE, 32'h0000_0000);
		chk(rd, 32'h0000_0080, "gate reset");
		chk(periph_clk_en, 8'h7F, "clocks reset");
		apb(1'b1, cfsg_pkg::OFF_GATE, 32'h0000_00FF);
		apb(1'b1, cfsg_pkg::OFF_GATE, 32'h0000_0000);
		apb(1'b0, cfsg_pkg::OFF_GATE, 32'h0000_0000);
		chk(rd, 32'h0000_0080, "absent module");
		apb(1'b0, 8'h1C, 32'h0000_0000);
		chk(err, 1'b1, "unmapped");
		$display("t_regs done");
	endtask

	task automatic t_gate;
		apb(1'b1, cfsg_pkg::OFF_GATE, 32'h0000_0005);
		@(negedge pclk);
		chk(periph_clk_en, 8'h7F, "gate too early");
		@(negedge pclk);
		chk(periph_clk_en, 8'h7A, "gate clocks");
		chk(periph_reg_en, 8'h7A, "gate registers");
		apb(1'b1, cfsg_pkg::OFF_GATE, 32'h0000_0000);
		cyc(1);
		@(negedge pclk);
		chk(periph_clk_en, 8'h7F, "ungate");
		$display("t_gate done");
	endtask

	// Ticks over 256 cycles give the divisor exactly, whatever the phase.
	task automatic t_doze;
		for (int r = 0; r < 9; r++) begin
			apb(1'b1, cfsg_pkg::OFF_CLOCK_DIV, (r == 8) ? 32'h0000_7000 : 32'h0000_0800 | (r << 12));
			cyc(140);
			t0 = ticks;
			cyc(256);
			chk(32'(ticks - t0), (r == 8) ? 32'd256 : 32'(256 >> r), "cpu ticks");
			chk({sys_clk_en, periph_clk_en}, 9'h17F, "full speed");
		end
		$display("t_doze done");
	endtask

	// A plain interrupt pulse while running; no power-save entry is involved here.
	task automatic t_ret;
		apb(1'b1, cfsg_pkg::OFF_IRQ_CLR, 32'h0000_0007);
		apb(1'b1, cfsg_pkg::OFF_IRQ_EN, 32'h0000_0000);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, cfsg_pkg::OFF_CLOCK_DIV, k ? 32'h0000_1800 : 32'h0000_A800);
			@(posedge pclk);
			irq_pend <= 1'b1;
			@(posedge pclk);
			irq_pend <= 1'b0;
			cyc(3);
			apb(1'b0, cfsg_pkg::OFF_CLOCK_DIV, 32'h0000_0000);
			chk(rd, k ? 32'h0000_1800 : 32'h0000_A000, "return on interrupt");
		end
		apb(1'b0, cfsg_pkg::OFF_IRQ_STAT, 32'h0000_0000);
		chk(rd, 32'h0000_0004, "event bit");
		@(negedge pclk);
		chk(irq, 1'b0, "masked");
		apb(1'b1, cfsg_pkg::OFF_IRQ_EN, 32'h0000_0004);
		cyc(1);
		@(negedge pclk);
		chk(irq, 1'b1, "raised");
		apb(1'b1, cfsg_pkg::OFF_IRQ_CLR, 32'h0000_0004);
		cyc(1);
		@(negedge pclk);
		chk(irq, 1'b0, "cleared");
		$display("t_ret done");
	endtask

	task automatic t_idle;
		@(posedge pclk);
		wdt_enable <= 1'b1;
		cyc(2);
		psave(1'b0, 1'b1);
		for (n = 1; n < 10; n++) begin
			@(negedge pclk);
			if (watchdog_timer_clr === 1'b1)
				chk({sys_clk_en, low_power_rc_osc_en}, 2'b11, "idle clocks");
			if (cpu_resume === 1'b1)
				break;
		end
		chk(n, 3, "deferred wake");
		psave(1'b0, 1'b0);
		cyc(6);
		@(negedge pclk);
		chk(cpu_run, 1'b0, "stays idle");
		@(posedge pclk);
		wdt_timeout <= 1'b1;
		@(posedge pclk);
		wdt_timeout <= 1'b0;
		@(negedge pclk);
		chk({cpu_resume, cpu_run}, 2'b11, "time-out wake");
		psave(1'b1, 1'b0);
		cyc(4);
		@(negedge pclk);
		chk({sys_clk_en, low_power_rc_osc_en}, 2'b00, "sleep clocks");
		@(posedge pclk);
		irq_pend <= 1'b1;
		@(posedge pclk);
		irq_pend <= 1'b0;
		@(negedge pclk);
		chk(cpu_resume, 1'b1, "sleep wake");
		$display("t_idle done");
	endtask

	task automatic t_fail;
		@(posedge pclk);
		wdt_enable <= 1'b0;
		osc_fail <= 1'b1;
		apb(1'b1, cfsg_pkg::OFF_IRQ_CLR, 32'h0000_0007);
		cyc(10);
		@(negedge pclk);
		chk({sys_src, trap_req, low_power_rc_osc_en}, 3'b000, "monitor off");
		@(posedge pclk);
		osc_fail <= 1'b0;
		clock_switch_monitor_cfg <= 1'b0;
		pll_mult_in <= 5'h0B;
		cyc(6);
		@(negedge pclk);
		chk({low_power_rc_osc_en, pll_mult_out}, 6'h2B, "monitor on");
		@(posedge pclk);
		osc_fail <= 1'b1;
		for (n = 0; n < 12 && sys_src !== 1'b1; n++)
			@(negedge pclk);
		chk({sys_src, trap_req}, 2'b11, "failover");
		@(posedge pclk);
		pll_mult_in <= 5'h03;
		cyc(3);
		@(negedge pclk);
		chk(pll_mult_out, 5'h0B, "factor kept");
		for (n = 0; n < 30 && trap_req !== 1'b0; n++)
			@(negedge pclk);
		chk({trap_req, acks}, 9'h001, "trap until ack");
		apb(1'b0, cfsg_pkg::OFF_IRQ_STAT, 32'h0000_0000);
		chk(rd, 32'h0000_0001, "failover event");
		// Once the primary recovers, software may switch back to it.
		@(posedge pclk);
		osc_fail <= 1'b0;
		cyc(3);
		apb(1'b1, cfsg_pkg::OFF_CTRL, 32'h0000_0001);
		cyc(2);
		@(negedge pclk);
		chk(sys_src, 1'b0, "back to primary");
		apb(1'b0, cfsg_pkg::OFF_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0062, "status view");
		$display("t_fail done");
	endtask

	// Watchdog sized well above the expected run of about 3,800 cycles.
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		results();
	end

	// Main sequence.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		clock_switch_monitor_cfg = 1'b1;
		osc_fail = 1'b0;
		pll_mult_in = 5'h00;
		wdt_enable = 1'b0;
		wdt_timeout = 1'b0;
		irq_pend = 1'b0;
		power_save_instr = 1'b0;
		power_save_sleep = 1'b0;
		fails = 0;
		check_count = 0;
		cyc(8);
		presetn <= 1'b1;
		t_regs();
		t_gate();
		t_doze();
		t_ret();
		t_idle();
		t_fail();
		results();
	end
endmodule
